// ---- rtl/dptc_channel.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dptc_defines.vh"

module dptc_channel (
	input  wire       clock,
	input  wire       srst,
	input  wire       pwm_en,
	input  wire [1:0] mode,
	input  wire [7:0] cmp,
	input  wire [7:0] top,
	input  wire       step,
	input  wire [7:0] cnt_nxt,
	output reg        true_r,
	output reg        comp_r
);
	wire hit = step && (cnt_nxt == cmp);
	wire at0 = step && (cnt_nxt == `DPTC_CNT_ZERO);
	wire at1 = step && (cnt_nxt == `DPTC_CNT_ONE);

	always @(posedge clock) begin
		if (srst) begin
			true_r <= 1'b0;
			comp_r <= 1'b0;
		end else if (!pwm_en) begin
			// normal mode only drives the true output
			if (hit) begin
				case (mode)
				`DPTC_MODE_01: true_r <= ~true_r;
				`DPTC_MODE_10: true_r <= 1'b0;
				`DPTC_MODE_11: true_r <= 1'b1;
				default:       true_r <= true_r;
				endcase
			end
		end else if (cmp == `DPTC_CNT_ZERO || cmp == top) begin
			// static levels, no edge ever lands
			case (mode)
			`DPTC_MODE_01: begin
				true_r <= (cmp != `DPTC_CNT_ZERO);
				comp_r <= (cmp == `DPTC_CNT_ZERO);
			end
			`DPTC_MODE_10: true_r <= (cmp != `DPTC_CNT_ZERO);
			`DPTC_MODE_11: true_r <= (cmp == `DPTC_CNT_ZERO);
			default:       true_r <= true_r;
			endcase
		end else begin
			case (mode)
			`DPTC_MODE_01: begin
				if (hit)
					true_r <= 1'b0;
				else if (at1)
					true_r <= 1'b1;
				if (hit)
					comp_r <= 1'b1;
				else if (at0)
					comp_r <= 1'b0;
			end
			`DPTC_MODE_10: begin
				if (hit)
					true_r <= 1'b0;
				else if (at1)
					true_r <= 1'b1;
			end
			`DPTC_MODE_11: begin
				if (hit)
					true_r <= 1'b1;
				else if (at1)
					true_r <= 1'b0;
			end
			default: true_r <= true_r;
			endcase
		end
	end
endmodule // dptc_channel

`default_nettype wire

// ---- rtl/dptc_defines.vh ----
`ifndef DPTC_DEFINES_VH
`define DPTC_DEFINES_VH

// register byte offsets
`define DPTC_OFS_CONTROL   8'h30
`define DPTC_OFS_COUNTER   8'h2f
`define DPTC_OFS_CMP_A     8'h2e
`define DPTC_OFS_TOP       8'h2d
`define DPTC_OFS_CHAN_B    8'h2c
`define DPTC_OFS_CMP_B     8'h2b
`define DPTC_OFS_FLAGS     8'h38
`define DPTC_OFS_IRQ_EN    8'h39

// counter_control fields
`define DPTC_CTL_CLEAR_TOP 7
`define DPTC_CTL_PWM_EN    6
`define DPTC_CTL_MODE_HI   5
`define DPTC_CTL_MODE_LO   4
`define DPTC_CTL_CS_HI     3
`define DPTC_CTL_CS_LO     0

// channel b / clock source register fields
`define DPTC_CHB_FAST_CLK  7
`define DPTC_CHB_PWM_EN    6
`define DPTC_CHB_MODE_HI   5
`define DPTC_CHB_MODE_LO   4

// flag and enable register fields
`define DPTC_FLG_GLOBAL    7
`define DPTC_FLG_MATCH_A   6
`define DPTC_FLG_MATCH_B   5
`define DPTC_FLG_TOP       2

// reset values
`define DPTC_RST_CONTROL   8'h00
`define DPTC_RST_TOP       8'hff
`define DPTC_RST_BYTE      8'h00

// output modes
`define DPTC_MODE_OFF      2'h0
`define DPTC_MODE_01       2'h1
`define DPTC_MODE_10       2'h2
`define DPTC_MODE_11       2'h3

// counter values where the pwm outputs restart, and where the count overflows
`define DPTC_CNT_ZERO      8'h00
`define DPTC_CNT_ONE       8'h01
`define DPTC_CNT_FULL      8'hff

// prescaler depth: codes 1..15 divide by 1..16384
`define DPTC_DIV_BITS      14

`endif

// ---- rtl/dptc_prescaler.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dptc_defines.vh"

module dptc_prescaler #(
	parameter DIV_BITS = `DPTC_DIV_BITS
) (
	input  wire                clock,
	input  wire                srst,
	input  wire [3:0]          sel,
	input  wire                src_tick,
	output reg                 tick_r
);
	reg  [DIV_BITS-1:0] div_r;
	wire [DIV_BITS:0]   mask;

	// code n passes one source tick in 2**(n-1)
	assign mask = ({{DIV_BITS{1'b0}}, 1'b1} << (sel - 4'h1)) -
		{{DIV_BITS{1'b0}}, 1'b1};

	always @(posedge clock) begin
		if (srst) begin
			div_r  <= {DIV_BITS{1'b0}};
			tick_r <= 1'b0;
		end else begin
			if (src_tick)
				div_r <= div_r + {{(DIV_BITS-1){1'b0}}, 1'b1};
			tick_r <= (sel != 4'h0) && src_tick &&
				((div_r & mask[DIV_BITS-1:0]) ==
				mask[DIV_BITS-1:0]);
		end
	end
endmodule // dptc_prescaler

`default_nettype wire

// ---- rtl/dptc_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dptc_defines.vh"

// What this block does
// - pwm counter runs zero to top, repeats
// - top flag set one sync cycle after
// - two 8-bit channels, true plus complement
// - compare match sets/clears per mode field
// - mode 01 true and complement edges
// - modes 10, 11 true edges, complement off
// - pwm compare writes buffered until top
// - compare reads return the buffer
// - compare zero or top gives static levels
// - top irq needs flag, enable, global enable
// - match flags and irqs like top
// - period is top plus one ticks
// - clear-on-match restarts counter after top
// - pwm enable a restarts counter after top
// - normal mode a: toggle, clear, set
// - pin driven only when direction is output
// - complement a off outside pwm mode
// - clock select stops or divides by power two
// - async mode counts fast peripheral clock
module dptc_top (
	input  wire       clock,
	input  wire       srst,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata_r,
	input  wire       fast_peripheral_clock,
	input  wire [4:0] port_dir,
	input  wire [4:0] port_data,
	output reg        port_pin_0_r,
	output reg        port_pin_0_oe_r,
	output reg        port_pin_1_r,
	output reg        port_pin_1_oe_r,
	output reg        port_pin_3_r,
	output reg        port_pin_3_oe_r,
	output reg        port_pin_4_r,
	output reg        port_pin_4_oe_r,
	output reg        irq_top_r,
	output reg        irq_match_a_r,
	output reg        irq_match_b_r
);
	reg  [7:0] counter_control_r;
	reg  [7:0] chan_b_control_r;
	reg  [7:0] counter_value_r;
	reg  [7:0] top_compare_value_r;
	reg  [7:0] compare_value_a_r;
	reg  [7:0] compare_value_b_r;
	reg  [7:0] cmp_a_buf_r;
	reg  [7:0] cmp_b_buf_r;
	reg        top_reached_flag_r;
	reg        match_flag_a_r;
	reg        match_flag_b_r;
	reg        top_evt_r;
	reg        match_a_evt_r;
	reg        match_b_evt_r;
	reg  [7:0] irq_en_r;
	reg  [7:0] cnt_nxt;
	reg  [7:0] rdata_nxt;

	wire       tick;
	wire       src_tick;
	wire       true_a;
	wire       comp_a;
	wire       true_b;
	wire       comp_b;

	wire clear_on_top_match = counter_control_r[`DPTC_CTL_CLEAR_TOP];
	wire pwm_enable_a       = counter_control_r[`DPTC_CTL_PWM_EN];
	wire pwm_enable_b       = chan_b_control_r[`DPTC_CHB_PWM_EN];
	wire fast_clk_mode      = chan_b_control_r[`DPTC_CHB_FAST_CLK];
	wire [1:0] out_mode_a   = {counter_control_r[`DPTC_CTL_MODE_HI],
		counter_control_r[`DPTC_CTL_MODE_LO]};
	wire [1:0] out_mode_b   = {chan_b_control_r[`DPTC_CHB_MODE_HI],
		chan_b_control_r[`DPTC_CHB_MODE_LO]};
	wire [3:0] clock_select = counter_control_r[`DPTC_CTL_CS_HI:
		`DPTC_CTL_CS_LO];
	wire pwm_any            = pwm_enable_a || pwm_enable_b;
	wire restart_at_top     = clear_on_top_match || pwm_any;
	wire at_top             = (counter_value_r == top_compare_value_r);
	wire wr_counter         = wr && (addr == `DPTC_OFS_COUNTER);
	wire wr_flags           = wr && (addr == `DPTC_OFS_FLAGS);
	wire wr_control         = wr && (addr == `DPTC_OFS_CONTROL);
	wire wr_chan_b          = wr && (addr == `DPTC_OFS_CHAN_B);
	wire wr_top             = wr && (addr == `DPTC_OFS_TOP);
	wire wr_irq_en          = wr && (addr == `DPTC_OFS_IRQ_EN);
	wire wr_cmp_a           = wr && (addr == `DPTC_OFS_CMP_A);
	wire wr_cmp_b           = wr && (addr == `DPTC_OFS_CMP_B);
	// a software counter write replaces the tick, so the count it
	// overrides makes no match, no wrap and no flag
	wire cnt_step           = tick && !wr_counter;
	wire wrap_top           = cnt_step && at_top && restart_at_top;
	wire wrap_full          = cnt_step && !wrap_top &&
		(counter_value_r == `DPTC_CNT_FULL);
	// write one to clear a flag
	wire clr_top            = wr_flags && wdata[`DPTC_FLG_TOP];
	wire clr_match_a        = wr_flags && wdata[`DPTC_FLG_MATCH_A];
	wire clr_match_b        = wr_flags && wdata[`DPTC_FLG_MATCH_B];

	// fast clock arrives as a one-cycle strobe in this domain; it
	// caps the usable rate at the system clock
	assign src_tick = fast_clk_mode ? fast_peripheral_clock : 1'b1;

	dptc_prescaler #(
		.DIV_BITS (`DPTC_DIV_BITS)
	) u_prescaler (
		.clock    (clock),
		.srst     (srst),
		.sel      (clock_select),
		.src_tick (src_tick),
		.tick_r   (tick)
	);

	// next counter value on a tick
	always @* begin
		cnt_nxt = counter_value_r + 8'h01;
		if (wrap_top)
			cnt_nxt = `DPTC_CNT_ZERO;
	end

	always @(posedge clock) begin
		if (srst)
			counter_value_r <= `DPTC_RST_BYTE;
		else if (wr_counter)
			counter_value_r <= wdata;
		else if (tick)
			counter_value_r <= cnt_nxt;
	end

	dptc_channel u_chan_a (
		.clock   (clock),
		.srst    (srst),
		.pwm_en  (pwm_enable_a),
		.mode    (out_mode_a),
		.cmp     (compare_value_a_r),
		.top     (top_compare_value_r),
		.step    (cnt_step),
		.cnt_nxt (cnt_nxt),
		.true_r  (true_a),
		.comp_r  (comp_a)
	);

	dptc_channel u_chan_b (
		.clock   (clock),
		.srst    (srst),
		.pwm_en  (pwm_enable_b),
		.mode    (out_mode_b),
		.cmp     (compare_value_b_r),
		.top     (top_compare_value_r),
		.step    (cnt_step),
		.cnt_nxt (cnt_nxt),
		.true_r  (true_b),
		.comp_r  (comp_b)
	);

	// control registers
	always @(posedge clock) begin
		if (srst)
			counter_control_r <= `DPTC_RST_CONTROL;
		else if (wr_control)
			counter_control_r <= wdata;
	end

	always @(posedge clock) begin
		if (srst)
			chan_b_control_r <= `DPTC_RST_BYTE;
		else if (wr_chan_b)
			chan_b_control_r <= wdata;
	end

	always @(posedge clock) begin
		if (srst)
			top_compare_value_r <= `DPTC_RST_TOP;
		else if (wr_top)
			top_compare_value_r <= wdata;
	end

	always @(posedge clock) begin
		if (srst)
			irq_en_r <= `DPTC_RST_BYTE;
		else if (wr_irq_en)
			irq_en_r <= wdata;
	end

	// holding buffers take every compare write
	always @(posedge clock) begin
		if (srst)
			cmp_a_buf_r <= `DPTC_RST_BYTE;
		else if (wr_cmp_a)
			cmp_a_buf_r <= wdata;
	end

	always @(posedge clock) begin
		if (srst)
			cmp_b_buf_r <= `DPTC_RST_BYTE;
		else if (wr_cmp_b)
			cmp_b_buf_r <= wdata;
	end

	// buffered values land only at the period boundary so
	// no odd-length pulse appears mid-period
	always @(posedge clock) begin
		if (srst)
			compare_value_a_r <= `DPTC_RST_BYTE;
		else if (!pwm_enable_a && wr_cmp_a)
			compare_value_a_r <= wdata;
		else if (pwm_enable_a && wrap_top)
			compare_value_a_r <= cmp_a_buf_r;
	end

	always @(posedge clock) begin
		if (srst)
			compare_value_b_r <= `DPTC_RST_BYTE;
		else if (!pwm_enable_b && wr_cmp_b)
			compare_value_b_r <= wdata;
		else if (pwm_enable_b && wrap_top)
			compare_value_b_r <= cmp_b_buf_r;
	end

	// events pass one sync stage before reaching the flags
	always @(posedge clock) begin
		if (srst) begin
			top_evt_r     <= 1'b0;
			match_a_evt_r <= 1'b0;
			match_b_evt_r <= 1'b0;
		end else begin
			top_evt_r     <= pwm_any ? wrap_top : wrap_full;
			match_a_evt_r <= cnt_step &&
				(cnt_nxt == compare_value_a_r);
			match_b_evt_r <= cnt_step &&
				(cnt_nxt == compare_value_b_r);
		end
	end

	// a set in the same cycle as a clear wins
	always @(posedge clock) begin
		if (srst)
			top_reached_flag_r <= 1'b0;
		else if (top_evt_r)
			top_reached_flag_r <= 1'b1;
		else if (clr_top)
			top_reached_flag_r <= 1'b0;
	end

	always @(posedge clock) begin
		if (srst)
			match_flag_a_r <= 1'b0;
		else if (match_a_evt_r)
			match_flag_a_r <= 1'b1;
		else if (clr_match_a)
			match_flag_a_r <= 1'b0;
	end

	always @(posedge clock) begin
		if (srst)
			match_flag_b_r <= 1'b0;
		else if (match_b_evt_r)
			match_flag_b_r <= 1'b1;
		else if (clr_match_b)
			match_flag_b_r <= 1'b0;
	end

	// requests follow the flags, gated by own and global enables
	always @(posedge clock) begin
		if (srst) begin
			irq_top_r     <= 1'b0;
			irq_match_a_r <= 1'b0;
			irq_match_b_r <= 1'b0;
		end else begin
			irq_top_r     <= top_reached_flag_r &&
				irq_en_r[`DPTC_FLG_TOP] &&
				irq_en_r[`DPTC_FLG_GLOBAL];
			irq_match_a_r <= match_flag_a_r &&
				irq_en_r[`DPTC_FLG_MATCH_A] &&
				irq_en_r[`DPTC_FLG_GLOBAL];
			irq_match_b_r <= match_flag_b_r &&
				irq_en_r[`DPTC_FLG_MATCH_B] &&
				irq_en_r[`DPTC_FLG_GLOBAL];
		end
	end

	// pin muxing: block owns a pin only when its mode connects it;
	// the enable always follows the direction bit
	always @(posedge clock) begin
		if (srst) begin
			port_pin_0_r    <= 1'b0;
			port_pin_0_oe_r <= 1'b0;
			port_pin_1_r    <= 1'b0;
			port_pin_1_oe_r <= 1'b0;
			port_pin_3_r    <= 1'b0;
			port_pin_3_oe_r <= 1'b0;
			port_pin_4_r    <= 1'b0;
			port_pin_4_oe_r <= 1'b0;
		end else begin
			port_pin_1_r <= (out_mode_a != `DPTC_MODE_OFF) ?
				true_a : port_data[1];
			port_pin_0_r <= (pwm_enable_a &&
				out_mode_a == `DPTC_MODE_01) ?
				comp_a : port_data[0];
			port_pin_4_r <= (out_mode_b != `DPTC_MODE_OFF) ?
				true_b : port_data[4];
			port_pin_3_r <= (pwm_enable_b &&
				out_mode_b == `DPTC_MODE_01) ?
				comp_b : port_data[3];
			port_pin_0_oe_r <= port_dir[0];
			port_pin_1_oe_r <= port_dir[1];
			port_pin_3_oe_r <= port_dir[3];
			port_pin_4_oe_r <= port_dir[4];
		end
	end

	// read mux
	always @* begin
		rdata_nxt = 8'h00;
		case (addr)
		`DPTC_OFS_CONTROL: rdata_nxt = counter_control_r;
		`DPTC_OFS_CHAN_B:  rdata_nxt = chan_b_control_r;
		`DPTC_OFS_COUNTER: rdata_nxt = counter_value_r;
		`DPTC_OFS_TOP:     rdata_nxt = top_compare_value_r;
		`DPTC_OFS_CMP_A:   rdata_nxt = cmp_a_buf_r;
		`DPTC_OFS_CMP_B:   rdata_nxt = cmp_b_buf_r;
		`DPTC_OFS_IRQ_EN:  rdata_nxt = irq_en_r;
		`DPTC_OFS_FLAGS: begin
			rdata_nxt[`DPTC_FLG_TOP]     = top_reached_flag_r;
			rdata_nxt[`DPTC_FLG_MATCH_A] = match_flag_a_r;
			rdata_nxt[`DPTC_FLG_MATCH_B] = match_flag_b_r;
		end
		default: rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge clock) begin
		if (srst)
			rdata_r <= 8'h00;
		else if (rd)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= 8'h00;
	end
endmodule // dptc_top

`default_nettype wire

// ---- sim/dptc_load.sv ----
`timescale 1ns/1ps
`default_nettype none
module dptc_load (
	input  wire logic [3:0] pin,
	input  wire logic [3:0] oe,
	output wire logic [3:0] lvl
);
	// undriven pins fall to the pull-down, never a stale level
	assign lvl = pin & oe;
endmodule // dptc_load
`default_nettype wire

// ---- sim/dptc_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module dptc_top_chk (
	input wire logic       clock,
	input wire logic       srst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata_r,
	input wire logic [4:0] port_dir,
	input wire logic [4:0] port_data,
	input wire logic       port_pin_0_r,
	input wire logic       port_pin_0_oe_r,
	input wire logic       port_pin_1_oe_r,
	input wire logic       port_pin_3_oe_r,
	input wire logic       port_pin_4_oe_r,
	input wire logic       irq_top_r,
	input wire logic       irq_match_a_r,
	input wire logic       irq_match_b_r
);
	logic       pwm_a_r;
	logic       gie_r;
	wire        irq = irq_top_r | irq_match_a_r | irq_match_b_r;
	wire  [3:0] dir_used = {port_dir[4:3], port_dir[1:0]};
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// shadows rebuilt from bus writes, since the checker sees no internals
	always @(posedge clock) begin
		if (srst) begin
			pwm_a_r <= 1'b0;
			gie_r <= 1'b0;
		end else if (wr && addr == 8'h30)
			pwm_a_r <= wdata[6];
		else if (wr && addr == 8'h39)
			gie_r <= wdata[7];
	end
	property back(a);
		wr && addr == a ##1 rd && addr == a |=> rdata_r == $past(wdata, 2);
	endproperty
	chk_ctl_back: assert property (back(8'h30))
		else $error("control readback");
	chk_cmp_a_back: assert property (back(8'h2e))
		else $error("compare a readback");
	chk_cmp_b_back: assert property (back(8'h2b))
		else $error("compare b readback");
	chk_top_back: assert property (back(8'h2d))
		else $error("top readback");
	chk_oe_dir: assert property (!$past(srst) |->
		{port_pin_4_oe_r, port_pin_3_oe_r, port_pin_1_oe_r,
		port_pin_0_oe_r} == $past(dir_used))
		else $error("enable not from direction");
	chk_comp_off: assert property (!$past(srst) && !pwm_a_r &&
		!$past(pwm_a_r) && !$past(pwm_a_r, 2) |->
		port_pin_0_r == $past(port_data[0]))
		else $error("complement a driven");
	chk_irq_gie: assert property (irq |-> $past(gie_r))
		else $error("irq without global enable");
	chk_irq_off: assert property (wr && addr == 8'h39 &&
		!wdata[7] |=> ##1 !irq)
		else $error("irq after disable");
	cover property ($rose(irq_top_r));
	cover property (pwm_a_r && $rose(irq_match_a_r));
	cover property (wr && addr == 8'h2e ##1 rd);
endmodule // dptc_top_chk
bind dptc_top dptc_top_chk u_chk (
	.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata_r(rdata_r), .port_dir(port_dir),
	.port_data(port_data), .port_pin_0_r(port_pin_0_r),
	.port_pin_0_oe_r(port_pin_0_oe_r), .port_pin_1_oe_r(port_pin_1_oe_r),
	.port_pin_3_oe_r(port_pin_3_oe_r), .port_pin_4_oe_r(port_pin_4_oe_r),
	.irq_top_r(irq_top_r), .irq_match_a_r(irq_match_a_r),
	.irq_match_b_r(irq_match_b_r)
);
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clock = 1'b0;
	logic       srst = 1'b1;
	logic       wr = 1'b0, rd = 1'b0, fpc = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic [4:0] dir = 5'h00, pdat = 5'h00;
	logic [3:0] pin, oe, lvl;
	logic       irq_t, irq_a, irq_b;
	logic [7:0] m [256];
	logic [7:0] regs [$] = '{8'h30, 8'h2e, 8'h2d, 8'h2c, 8'h2b, 8'h39, 8'h00};
	int         fail_count = 0, n_tests = 0, cyc = 0, t, c, cm, h1, h0, ov;
	int         h3, h4;
	always #20 clock = ~clock;
	// fast clock pulses every second cycle, so it ticks at half rate
	always @(posedge clock) fpc <= ~fpc;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			end_of_test();
		end
	end
	dptc_top DUT (
		.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_r(rdata), .fast_peripheral_clock(fpc),
		.port_dir(dir), .port_data(pdat),
		.port_pin_0_r(pin[0]), .port_pin_0_oe_r(oe[0]),
		.port_pin_1_r(pin[1]), .port_pin_1_oe_r(oe[1]),
		.port_pin_3_r(pin[2]), .port_pin_3_oe_r(oe[2]),
		.port_pin_4_r(pin[3]), .port_pin_4_oe_r(oe[3]),
		.irq_top_r(irq_t), .irq_match_a_r(irq_a), .irq_match_b_r(irq_b));
	dptc_load u_load (.pin(pin), .oe(oe), .lvl(lvl));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bw(input logic [7:0] a, input logic [7:0] d, input bit rb);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		rd <= rb;
		if (a != 8'h00)
			m[a] = d;
		if (rb) begin
			@(posedge clock);
			rd <= 1'b0;
			@(negedge clock);
			chk(rdata, m[a]);
		end
	endtask
	task automatic br(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		v = rdata;
	endtask
	function automatic int hi1(input int md, input int k);
		if (md == 0)
			return k * (t + 1) * pdat[1];
		if (c == 0)
			return md == 3 ? k * (t + 1) : 0;
		if (c == t)
			return md == 3 ? 0 : k * (t + 1);
		return k * (md == 3 ? t - c + 2 : c - 1);
	endfunction
	function automatic int hi0(input int md, input int k);
		if (md != 1)
			return k * (t + 1) * pdat[0];
		return c == t ? 0 : k * (t - c + 1);
	endfunction
	// one whole period window: high counts are phase independent
	task automatic duty(input int k, input int md);
		repeat (3 * k * (t + 1)) @(posedge clock);
		h1 = 0;
		h0 = 0;
		ov = 0;
		h3 = 0;
		h4 = 0;
		repeat (k * (t + 1)) begin
			@(negedge clock);
			h1 += lvl[1];
			h0 += lvl[0];
			h3 += lvl[2];
			h4 += lvl[3];
			ov += lvl[1] & lvl[0];
		end
		chk(8'(h4), 8'(k * (t + 1) * pdat[4]));
		chk(8'(h3), 8'(k * (t + 1) * pdat[3]));
		chk(8'(h1), 8'(hi1(md, k)));
		chk(8'(h0), 8'(hi0(md, k)));
		chk(8'(md == 1 ? ov : 0), 8'h00);
	endtask
	initial begin
		t = $urandom(32'h4678b702);
		foreach (m[i]) m[i] = 8'h00;
		m[8'h2d] = 8'hff;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		foreach (regs[i]) begin
			br(regs[i]);
			chk(v, m[regs[i]]);
		end
		foreach (regs[i]) bw(regs[i], 8'($urandom), 1);
		$display("end: registers");
		bw(8'h2c, 8'h00, 0);
		bw(8'h30, 8'h00, 0);
		bw(8'h2f, 8'h5a, 0);
		repeat (20) @(posedge clock);
		br(8'h2f);
		chk(v, 8'h5a);
		$display("end: stopped");
		t = 4 + $urandom % 8;
		cm = 2 + $urandom % (t - 2);
		bw(8'h2d, 8'(t), 1);
		bw(8'h2f, 8'h00, 0);
		bw(8'h30, 8'h81, 0);
		repeat (8) begin
			repeat ($urandom % 7) @(posedge clock);
			br(8'h2f);
			chk(8'(v > t), 8'h00);
		end
		$display("end: clear on top");
		@(posedge clock);
		dir <= 5'h1f;
		pdat <= 5'($urandom);
		for (int md = 0; md < 4; md++)
			for (int j = 0; j < 3; j++) begin
				c = j == 0 ? 0 : j == 1 ? cm : t;
				bw(8'h2e, 8'(c), 1);
				bw(8'h30, 8'h41 | 8'(md << 4), 0);
				duty(1, md);
			end
		$display("end: pwm modes");
		c = cm;
		bw(8'h2e, 8'(c), 0);
		for (int j = 0; j < 2; j++) begin
			bw(8'h2c, j ? 8'h80 : 8'h00, 0);
			bw(8'h30, j ? 8'h51 : 8'h52, 0);
			duty(2, 1);
		end
		$display("end: clock sources");
		bw(8'h2b, 8'h00, 0);
		bw(8'h39, 8'he4, 0);
		repeat (4 * (t + 1)) @(posedge clock);
		br(8'h38);
		chk(v & 8'h64, 8'h64);
		chk({5'h00, irq_t, irq_a, irq_b}, 8'h07);
		bw(8'h39, 8'h64, 0);
		repeat (2) @(negedge clock);
		chk({5'h00, irq_t, irq_a, irq_b}, 8'h00);
		$display("end: interrupts");
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
